// ---- rtl/intermittent_earth_fault_stage.sv ----
// Intermittent transient earth fault stage: peak detection, timers, start and trip
// Assumes samples synchronous to clk_sys and a plain strobe register port
//
// Summary of operation
// - Samples are taken every 625 us, 32 per 50 Hz cycle.
// - Direction is judged per instantaneous sample of current and voltage.
// - A peak is a sample above a fixed pick-up; sign gives direction.
// - Start output is high while the stage times a fault.
// - A peak counts only when above the fundamental component's peak.
// - External block input prevents both start and trip.
// - Trip needs delay elapsed, peaks reached, intermittent time not expired.
// - Trip output is held for the settable reset delay.
// - Peak count accepts 1 to 20; operation delay 0.02 to 300 s.
// - Intermittent time accepts 0.01 to 300 s.
// - Operation delay starts at first peak; count met at configured peaks.
// - Delay expired without peaks: wait, release when intermittent time expires.
// - Last peak after delay but within intermittent time trips at once.
// - Intermittent time expiring before the delay releases without trip.
// - Delay below peak count times 10 ms is rejected.
// - A new peak continues the operation delay count.
// - Direction mode selects forward or reverse peaks.
//
// Design decisions made here: strobed register access and the register offsets.
module intermittent_earth_fault_stage
  import ief_pkg::*;
#(
  parameter int SampleCycles = SAMPLE_CYCLES
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // Register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdData,
  // Measurement and blocking
  input  wire sample_t           sampleIn,
  output logic                   sampleTake,
  input  wire logic              blockIn,
  // Stage outputs
  output logic                   startOut,
  output logic                   tripOut
);

  localparam int DIV_W = $clog2(SampleCycles);
  localparam logic [MS_W-1:0] CNT_MAX = {MS_W{1'b1}};
  localparam logic [PK_W-1:0] PK_MAX  = {PK_W{1'b1}};

  logic [DIV_W-1:0]  divCnt_q;
  logic              sampleTick;
  logic              enable_q, revMode_q, reject_q, above_q;
  logic [MS_W-1:0]   opMs_q, intMs_q, rstMs_q;
  logic [PK_W-1:0]   minPeaks_q;
  logic [SMP_W-1:0]  uPick_q;
  logic [DATA_W-1:0] rdData_q, rdMux, statusWord;
  stage_state_t      state_q, state_d;
  logic [MS_W-1:0]   opCnt_q, opCnt_d, intCnt_q, intCnt_d, rstCnt_q, rstCnt_d;
  logic [PK_W-1:0]   peakCnt_q, peakCnt_d;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // Elapsed test: count * sample period reaches the setting, i.e. rounded up
  function automatic logic elapsed(input logic [MS_W-1:0] cnt, input logic [MS_W-1:0] ms);
    return (32'(cnt) * 32'(SAMPLE_PERIOD_US)) >= (32'(ms) * 32'(US_PER_MS));
  endfunction

  // Saturating increment of a sample counter
  function automatic logic [MS_W-1:0] bump(input logic [MS_W-1:0] cnt);
    return (cnt == CNT_MAX) ? cnt : cnt + 19'h00001;
  endfunction

  // Sample instant divider
  assign sampleTick = (divCnt_q == DIV_W'(SampleCycles - 1));
  assign sampleTake = sampleTick;

  always_ff @(posedge clk_sys) begin
    if (sys_rst || sampleTick) divCnt_q <= '0;
    else divCnt_q <= divCnt_q + 1'b1;
  end

  tick_spacing_a: assert property (sampleTick |=> !sampleTick [*8])
    else $error("sample instants too close");
  tick_follow_a: assert property (divCnt_q == DIV_W'(SampleCycles - 2) |=> sampleTick)
    else $error("sample instant missing");

  // Register write decode
  wire wrCtrl = regWr && (regAddr == ADDR_CTRL);
  wire wrOp   = regWr && (regAddr == ADDR_OPDLY);
  wire wrPk   = regWr && (regAddr == ADDR_PEAKS);
  wire wrInt  = regWr && (regAddr == ADDR_INTRMT);
  wire wrRst  = regWr && (regAddr == ADDR_RSTDLY);
  wire wrUpk  = regWr && (regAddr == ADDR_UPICK);
  wire cfgWr  = wrOp || wrPk || wrInt || wrRst;

  // Setting validation against ranges and peak spacing
  wire [31:0] pkFloorMs = 32'(minPeaks_q) * 32'(PEAK_SPACING_MS);
  wire opOk  = regWrData >= 32'(OPDLY_MIN_MS) && regWrData <= 32'(OPDLY_MAX_MS)
            && regWrData >= pkFloorMs;
  wire pkOk  = regWrData >= 32'(PEAKS_MIN) && regWrData <= 32'(PEAKS_MAX)
            && (regWrData * 32'(PEAK_SPACING_MS)) <= 32'(opMs_q);
  wire intOk = regWrData >= 32'(INT_MIN_MS) && regWrData <= 32'(INT_MAX_MS);
  wire rstOk = regWrData >= 32'(RST_MIN_MS) && regWrData <= 32'(RST_MAX_MS);
  wire cfgOk = (wrOp && opOk) || (wrPk && pkOk) || (wrInt && intOk) || (wrRst && rstOk);

  // Setting registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      enable_q   <= 1'b0;
      revMode_q  <= 1'b0;
      opMs_q     <= RST_OPDLY_MS;
      minPeaks_q <= RST_PEAKS;
      intMs_q    <= RST_INTRMT_MS;
      rstMs_q    <= RST_RSTDLY_MS;
      uPick_q    <= RST_UPICK;
      reject_q   <= 1'b0;
    end else begin
      if (wrCtrl) begin
        enable_q  <= regWrData[CTRL_EN_BIT];
        revMode_q <= regWrData[CTRL_DIR_BIT];
      end
      if (wrOp && opOk) opMs_q <= regWrData[MS_W-1:0];
      if (wrPk && pkOk) minPeaks_q <= regWrData[PK_W-1:0];
      if (wrInt && intOk) intMs_q <= regWrData[MS_W-1:0];
      if (wrRst && rstOk) rstMs_q <= regWrData[MS_W-1:0];
      if (wrUpk) uPick_q <= regWrData[SMP_W-1:0];
      if (cfgWr) reject_q <= !cfgOk;
    end
  end

  op_floor_a: assert property (wrOp && regWrData < pkFloorMs |=> opMs_q == $past(opMs_q))
    else $error("operation delay below peak spacing accepted");
  pk_floor_a: assert property (wrPk && (regWrData * 32'(PEAK_SPACING_MS)) > 32'(opMs_q)
                               |=> minPeaks_q == $past(minPeaks_q) && reject_q)
    else $error("peak count above delay limit accepted");
  pk_range_a: assert property (minPeaks_q >= 5'(PEAKS_MIN) && minPeaks_q <= 5'(PEAKS_MAX))
    else $error("peak count out of range");

  // Magnitudes and direction of the present sample
  wire [SMP_W-1:0] absI = sampleIn.current[SMP_W-1] ? SMP_W'(-sampleIn.current)
                                                    : SMP_W'(sampleIn.current);
  wire [SMP_W-1:0] absU = sampleIn.voltage[SMP_W-1] ? SMP_W'(-sampleIn.voltage)
                                                    : SMP_W'(sampleIn.voltage);
  wire aboveNow = (absI > PICKUP_LEVEL) && (absI > sampleIn.fundPeak);
  wire fwdDir   = sampleIn.current[SMP_W-1] != sampleIn.voltage[SMP_W-1];
  wire dirOk    = fwdDir ^ revMode_q;
  wire active   = enable_q && !blockIn;
  wire peakHit  = sampleTick && aboveNow && !above_q && dirOk
               && (absU > uPick_q) && active;

  // Leading sample of each transient; one transient counts once
  always_ff @(posedge clk_sys) begin
    if (sys_rst) above_q <= 1'b0;
    else if (sampleTick) above_q <= aboveNow;
  end

  fund_gate_a: assert property (peakHit |-> absI > sampleIn.fundPeak && absI > PICKUP_LEVEL)
    else $error("peak accepted below fundamental peak");

  // Timer look-ahead for the present sample instant
  wire [MS_W-1:0] opNext  = bump(opCnt_q);
  wire [MS_W-1:0] intNext = peakHit ? '0 : bump(intCnt_q);
  wire [PK_W-1:0] pkNext  = (peakHit && peakCnt_q != PK_MAX) ? peakCnt_q + 5'h01 : peakCnt_q;
  wire [MS_W-1:0] rstNext = bump(rstCnt_q);
  wire opDone  = elapsed(opNext, opMs_q);
  wire intDone = elapsed(intNext, intMs_q);
  wire cntDone = pkNext >= minPeaks_q;
  wire goTrip  = opDone && cntDone && !intDone;
  wire goRel   = intDone && !goTrip;
  wire rstDone = elapsed(rstNext, rstMs_q);

  // Stage sequencing and timers
  always_comb begin
    state_d   = state_q;
    opCnt_d   = opCnt_q;
    intCnt_d  = intCnt_q;
    rstCnt_d  = rstCnt_q;
    peakCnt_d = peakCnt_q;
    if (!active) begin
      state_d   = S_IDLE;
      opCnt_d   = '0;
      intCnt_d  = '0;
      rstCnt_d  = '0;
      peakCnt_d = '0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (peakHit) begin
            state_d   = S_TIMING;
            opCnt_d   = '0;
            intCnt_d  = '0;
            peakCnt_d = pkNext;
          end
        end
        S_TIMING: begin
          if (sampleTick) begin
            opCnt_d   = opNext;
            intCnt_d  = intNext;
            peakCnt_d = pkNext;
            if (goTrip) begin
              state_d  = S_TRIPPED;
              rstCnt_d = '0;
            end else if (goRel) begin
              state_d   = S_IDLE;
              opCnt_d   = '0;
              intCnt_d  = '0;
              peakCnt_d = '0;
            end
          end
        end
        S_TRIPPED: begin
          if (sampleTick) begin
            rstCnt_d = rstNext;
            if (rstDone) begin
              state_d   = S_IDLE;
              opCnt_d   = '0;
              intCnt_d  = '0;
              rstCnt_d  = '0;
              peakCnt_d = '0;
            end
          end
        end
        default: begin
          state_d   = S_IDLE;
          opCnt_d   = '0;
          intCnt_d  = '0;
          rstCnt_d  = '0;
          peakCnt_d = '0;
        end
      endcase
    end
  end

  // Sequencing registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q   <= S_IDLE;
      opCnt_q   <= '0;
      intCnt_q  <= '0;
      rstCnt_q  <= '0;
      peakCnt_q <= '0;
    end else begin
      state_q   <= state_d;
      opCnt_q   <= opCnt_d;
      intCnt_q  <= intCnt_d;
      rstCnt_q  <= rstCnt_d;
      peakCnt_q <= peakCnt_d;
    end
  end

  // Stage outputs straight from the state register
  assign startOut = (state_q != S_IDLE);
  assign tripOut  = (state_q == S_TRIPPED);

  // First peak opens timing with a fresh operation delay
  sequence firstPeak_s;
    state_q == S_IDLE && peakHit;
  endsequence
  sequence timingOpen_s;
    startOut && !tripOut && opCnt_q == '0 && peakCnt_q == 5'h01;
  endsequence
  start_peak_a: assert property (firstPeak_s |=> timingOpen_s)
    else $error("first peak did not open timing");

  block_quiet_a: assert property (blockIn |=> !startOut && !tripOut)
    else $error("stage active while blocked");

  op_continue_a: assert property (state_q == S_TIMING && sampleTick && peakHit && !goTrip && !goRel
                                  |=> opCnt_q == bump($past(opCnt_q)) && intCnt_q == '0)
    else $error("peak restarted operation delay");

  trip_cause_a: assert property ($rose(tripOut) |-> $past(opDone && cntDone && !intDone))
    else $error("trip without all conditions");

  late_peak_a: assert property (state_q == S_TIMING && active && sampleTick && peakHit && opDone
                                && pkNext == minPeaks_q && !intDone |=> tripOut)
    else $error("late final peak did not trip");

  early_rel_a: assert property (state_q == S_TIMING && active && sampleTick && intDone && !opDone
                                |=> !startOut && !tripOut && peakCnt_q == '0)
    else $error("intermittent expiry did not release");

  trip_hold_a: assert property (tripOut && active && !(sampleTick && rstDone) |=> tripOut)
    else $error("trip released before reset delay");

  // Status word shows the stage's state, the reject flag and the block input
  assign statusWord = (32'(peakCnt_q) << STAT_PK_LO)
                    | (32'(reject_q) << STAT_REJECT)
                    | (32'(blockIn) << STAT_BLOCK)
                    | (32'(tripOut) << STAT_TRIP)
                    | (32'(startOut) << STAT_START);

  // Read selection; unmapped addresses read zero
  always_comb begin
    case (regAddr)
      ADDR_CTRL:   rdMux = (32'(revMode_q) << CTRL_DIR_BIT) | (32'(enable_q) << CTRL_EN_BIT);
      ADDR_OPDLY:  rdMux = 32'(opMs_q);
      ADDR_PEAKS:  rdMux = 32'(minPeaks_q);
      ADDR_INTRMT: rdMux = 32'(intMs_q);
      ADDR_RSTDLY: rdMux = 32'(rstMs_q);
      ADDR_UPICK:  rdMux = 32'(uPick_q);
      ADDR_STATUS: rdMux = statusWord;
      default:     rdMux = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !regRd) rdData_q <= '0;
    else rdData_q <= rdMux;
  end

  assign regRdData = rdData_q;

endmodule

// ---- rtl/ief_pkg.sv ----
// Constants and types of the intermittent transient earth fault stage
// Assumes one 100 MHz system clock and samples presented on that clock
package ief_pkg;

  // Clock and sampling timing
  localparam int CLK_PERIOD_NS     = 10;
  localparam int SAMPLE_PERIOD_US  = 625;
  localparam int SAMPLE_CYCLES     = SAMPLE_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int SAMPLES_PER_CYCLE = 32;
  localparam int US_PER_MS         = 1000;
  localparam int PEAK_SPACING_MS   = 10;

  // Setting ranges, milliseconds or peaks
  localparam int OPDLY_MIN_MS = 20;
  localparam int OPDLY_MAX_MS = 300000;
  localparam int INT_MIN_MS   = 10;
  localparam int INT_MAX_MS   = 300000;
  localparam int RST_MIN_MS   = 60;
  localparam int RST_MAX_MS   = 300000;
  localparam int PEAKS_MIN    = 1;
  localparam int PEAKS_MAX    = 20;

  // Widths
  localparam int MS_W   = 19;
  localparam int PK_W   = 5;
  localparam int SMP_W  = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_OPDLY  = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PEAKS  = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_INTRMT = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_RSTDLY = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_UPICK  = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h18;

  // Field positions
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_DIR_BIT = 1;
  localparam int STAT_START   = 0;
  localparam int STAT_TRIP    = 1;
  localparam int STAT_BLOCK   = 2;
  localparam int STAT_REJECT  = 3;
  localparam int STAT_PK_LO   = 8;

  // Reset values
  localparam logic [MS_W-1:0]  RST_OPDLY_MS  = 19'h00014;
  localparam logic [PK_W-1:0]  RST_PEAKS     = 5'h01;
  localparam logic [MS_W-1:0]  RST_INTRMT_MS = 19'h0000A;
  localparam logic [MS_W-1:0]  RST_RSTDLY_MS = 19'h0003C;
  localparam logic [SMP_W-1:0] RST_UPICK     = 16'h0400;

  // Fixed residual current pick-up level
  localparam logic [SMP_W-1:0] PICKUP_LEVEL = 16'h0800;

  // One set of inputs taken at a sample instant
  typedef struct packed {
    logic signed [SMP_W-1:0] current;
    logic signed [SMP_W-1:0] voltage;
    logic        [SMP_W-1:0] fundPeak;
  } sample_t;

  // Stage sequencing
  typedef enum logic [2:0] {
    S_IDLE    = 3'b001,
    S_TIMING  = 3'b010,
    S_TRIPPED = 3'b100
  } stage_state_t;

endpackage

// ---- testbench/sample_source.sv ----
// Sample source model: residual current and zero sequence voltage per sample instant
// Assumes the stage pulses sampleTake once per sample and the bench picks the waveform kind
module sample_source
  import ief_pkg::*;
(
  // Clock
  input  wire logic       clk_sys,
  // Waveform choice and sample strobe
  input  wire logic [1:0] kind,
  input  wire logic       sampleTake,
  // Samples to the stage
  output sample_t         sampleIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] kind_q = 2'h0;

  // Waveform latched at each sample instant, so it stands for one whole interval
  always @(posedge clk_sys) if (sampleTake) kind_q <= kind;

  // Forward has opposite signs, reverse equal signs, steady a peak equal to its fundamental
  always_comb begin
    case (kind_q)
      2'h1:    sampleIn = '{16'sh1000, 16'shF800, 16'h0000};
      2'h2:    sampleIn = '{16'sh1000, 16'sh0800, 16'h0000};
      2'h3:    sampleIn = '{16'sh1000, 16'shF800, 16'h1000};
      default: sampleIn = '{16'sh0010, 16'sh0000, 16'h0000};
    endcase
  end
endmodule

// ---- testbench/tb_intermittent_earth_fault_stage.sv ----
// Self-checking bench of the intermittent transient earth fault stage
// Assumes sample_source on the sample link and a short sample divider
module tb_intermittent_earth_fault_stage
  import ief_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SmpCyc = 10;
  logic              clk_sys, sys_rst, regWr, regRd, blockIn, sampleTake, startOut, tripOut;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData, regRdData, d;
  logic [1:0]        kind;
  sample_t           sampleIn;
  int                n_mismatch, check_count, n;
  logic              sawTrip;

  intermittent_earth_fault_stage #(.SampleCycles(SmpCyc)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .sampleIn(sampleIn), .sampleTake(sampleTake), .blockIn(blockIn), .startOut(startOut), .tripOut(tripOut));
  sample_source src (.clk_sys(clk_sys), .kind(kind), .sampleTake(sampleTake), .sampleIn(sampleIn));

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check_val(input string what, input logic [DATA_W-1:0] exp, got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic check_bit(input string what, input logic exp, got);
    check_val(what, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk_sys);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= v;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk_sys);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdData;
    check_val("register", exp, d);
  endtask
  // Returns at the edge that takes each sample
  task automatic wait_samples(input int k);
    repeat (k) do @(posedge clk_sys); while (sampleTake !== 1'b1);
  endtask
  // One peak sample of the given kind, returns two edges after the edge the stage takes it
  task automatic send(input logic [1:0] k);
    @(posedge clk_sys);
    kind <= k;
    wait_samples(1);
    kind <= 2'h0;
    wait_samples(1);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic step();
    wait_samples(1);
    repeat (2) @(posedge clk_sys);
    #1 n++;
    if (tripOut === 1'b1) sawTrip = 1'b1;
  endtask
  task automatic setup(input logic [1:0] c, input int op, pk, it, rd);
    reg_write(ADDR_CTRL, 32'h0);
    reg_write(ADDR_PEAKS, 32'h1);
    reg_write(ADDR_OPDLY, op);
    reg_write(ADDR_PEAKS, pk);
    reg_write(ADDR_INTRMT, it);
    reg_write(ADDR_RSTDLY, rd);
    reg_write(ADDR_CTRL, {30'h0, c});
    n = 0;
    sawTrip = 1'b0;
  endtask

  task automatic t_regs();
    rd_chk(ADDR_OPDLY, 32'h14);
    rd_chk(ADDR_PEAKS, 32'h1);
    rd_chk(ADDR_INTRMT, 32'hA);
    rd_chk(ADDR_RSTDLY, 32'h3C);
    rd_chk(ADDR_UPICK, 32'h400);
    reg_write(ADDR_PEAKS, 32'h15);
    rd_chk(ADDR_PEAKS, 32'h1);
    rd_chk(ADDR_STATUS, 32'h8);
    reg_write(ADDR_OPDLY, 32'h28);
    reg_write(ADDR_PEAKS, 32'h5);
    rd_chk(ADDR_PEAKS, 32'h1);
    reg_write(ADDR_PEAKS, 32'h4);
    rd_chk(ADDR_PEAKS, 32'h4);
    reg_write(ADDR_OPDLY, 32'h27);
    rd_chk(ADDR_OPDLY, 32'h28);
    reg_write(ADDR_INTRMT, 32'h9);
    rd_chk(ADDR_INTRMT, 32'hA);
    rd_chk(8'h1C, 32'h0);
  endtask
  task automatic t_basic();
    setup(2'h1, 20, 1, 100, 60);
    send(2'h1);
    check_bit("start", 1'b1, startOut);
    while (tripOut !== 1'b1 && n < 40) step();
    check_val("trip delay", 32'd32, n);
    n = 0;
    while (tripOut === 1'b1 && n < 200) step();
    check_bit("hold span", 1'b1, n >= 95 && n <= 97);
    check_bit("start off", 1'b0, startOut);
  endtask
  task automatic t_direction();
    setup(2'h1, 20, 1, 100, 60);
    send(2'h2);
    check_bit("reverse ignored", 1'b0, startOut);
    send(2'h3);
    check_bit("steady ignored", 1'b0, startOut);
    reg_write(ADDR_UPICK, 32'h900);
    send(2'h1);
    check_bit("low voltage ignored", 1'b0, startOut);
    reg_write(ADDR_UPICK, 32'h400);
    setup(2'h3, 20, 1, 100, 60);
    send(2'h2);
    check_bit("reverse counted", 1'b1, startOut);
  endtask
  task automatic t_block();
    setup(2'h1, 20, 1, 100, 60);
    blockIn <= 1'b1;
    send(2'h1);
    check_bit("blocked start", 1'b0, startOut);
    @(posedge clk_sys);
    blockIn <= 1'b0;
    send(2'h1);
    check_bit("start", 1'b1, startOut);
    @(posedge clk_sys);
    blockIn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 check_bit("block clears", 1'b0, startOut);
    rd_chk(ADDR_STATUS, 32'h4);
    @(posedge clk_sys);
    blockIn <= 1'b0;
  endtask
  task automatic t_release(input int op, it, exp, input logic second);
    setup(2'h1, op, 2, it, 60);
    send(2'h1);
    if (second) begin
      wait_samples(4);
      send(2'h1);
    end
    while (startOut === 1'b1 && n < 80) step();
    check_val("release span", exp, n);
    check_bit("no trip", 1'b0, sawTrip);
  endtask
  task automatic t_late_peak();
    setup(2'h1, 20, 2, 100, 60);
    send(2'h1);
    wait_samples(40);
    repeat (2) @(posedge clk_sys);
    #1 check_bit("waiting trip", 1'b0, tripOut);
    check_bit("waiting start", 1'b1, startOut);
    send(2'h1);
    check_bit("late trip", 1'b1, tripOut);
    rd_chk(ADDR_STATUS, 32'h203);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_mismatch++;
    summarize();
  end

  // Main sequence
  initial begin
    {sys_rst, regWr, regRd, blockIn, kind, regAddr, regWrData} = '0;
    sys_rst = 1'b1;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs();
    t_basic();
    t_direction();
    t_block();
    t_release(40, 10, 16, 1'b1);
    t_release(20, 30, 48, 1'b0);
    t_late_peak();
    summarize();
  end
endmodule
